// file: core/port_event_pkg.sv
/*
 Shared constants and types for the port event unit: register offsets,
 reset values, edge mode encodings and the bus carrier structs.
 Assumes a single AHB-Lite slave with 32-bit data on one clock.
*/
package port_event_pkg;

   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_MASK = 8'h08;
   localparam logic [7:0] OFS_THRESH = 8'h0c;
   localparam logic [7:0] OFS_INDIS = 8'h10;
   localparam logic [7:0] OFS_SIO_OUT = 8'h14;
   localparam logic [7:0] OFS_SIO_REF = 8'h18;
   localparam logic [7:0] OFS_PINS = 8'h1c;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [15:0] RST_MODE = 16'h0000;
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic RST_THRESH = 1'b0;
   localparam logic [7:0] RST_INDIS = 8'h00;
   localparam logic [7:0] RST_SIO_OUT = 8'h00;
   localparam logic [7:0] RST_SIO_REF = 8'h00;

   // ----------------------------------------
   // Field layout and widths
   // ----------------------------------------
   localparam int PIN_COUNT = 8;
   localparam int MODE_W = 2;
   localparam int REF_W = 2;
   localparam int SYNC_STAGES = 3;

   // ----------------------------------------
   // Enumerations
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      EDGE_NONE = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_FALL = 2'b10,
      EDGE_BOTH = 2'b11
   } edge_mode_t;

   typedef enum logic [1:0]
   {
      REF_HALF_IO = 2'b00,
      REF_04_IO = 2'b01,
      REF_HALF_VREF = 2'b10,
      REF_FULL_VREF = 2'b11
   } sio_ref_t;

   typedef enum logic [1:0]
   {
      DRIVE_ANALOG_HIZ = 2'b00,
      DRIVE_DIGITAL_HIZ = 2'b01,
      DRIVE_PULL_UP = 2'b10,
      DRIVE_PULL_DOWN = 2'b11
   } drive_mode_t;

   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

   // ----------------------------------------
   // Bus carrier structs
   // ----------------------------------------
   typedef struct packed
   {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hready;
   } ahb_req_t;

   typedef struct packed
   {
      logic valid;
      logic write;
      logic [7:0] addr;
   } ahb_phase_t;

endpackage

// file: core/port_event_unit.sv
/*
 Port event unit for one eight-pin port: edge detection, sticky status,
 interrupt, input buffer and special pin configuration, AHB-Lite slave.
 Assumes pins are asynchronous to hclk and that the interrupt controller
 samples irq as a level; no wait states are ever inserted.
*/
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
// What this block does
// - Eight port pins feed one event unit driving its own interrupt line.
// - Every pin picks rising, falling, both edges or none, independently.
// - A matching edge sets that pin's status bit and raises the interrupt unless that pin's mask bit is set.
// - Own interrupt line and per-pin status register name the source pin.
// - Detection is sampled on hclk through the three-stage pin synchronisers, so edges are seen only while hclk runs.
// - Only edges are detected; no level-sensitive mode exists.
// - One port-wide threshold select, standard by default, low-voltage TTL otherwise.
// - Each pin input buffer can be disabled regardless of drive mode.
// - Each special pin selects supply-level or regulated high output.
// - Regulated special pins cannot use resistive pull-up or pull-down.
// - Special pins paired; each pair gets one four-way threshold reference field, only stored and read back, driving no output.
module port_event_unit
   import port_event_pkg::*;
#(
   parameter int PINS = PIN_COUNT
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [PINS-1:0] pin_in,
   input wire logic [2*PINS-1:0] pin_drive_mode,
   output logic irq,
   output logic low_voltage_ttl_threshold,
   output logic [PINS-1:0] input_buffer_disable,
   output logic [PINS-1:0] special_io_pin_regulated,
   output logic [PINS-1:0] pull_block,
   output logic [PINS-1:0] pin_event
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [2*PINS-1:0] mode_q;
   logic [PINS-1:0] status_q;
   logic [PINS-1:0] status_d;
   logic [PINS-1:0] mask_q;
   logic thresh_q;
   logic [PINS-1:0] indis_q;
   logic [PINS-1:0] sio_out_q;
   logic [PINS-1:0] sio_ref_q;
   logic [SYNC_STAGES-1:0] sync_q [PINS];
   logic [PINS-1:0] level_q;
   logic [PINS-1:0] hit_d;
   ahb_phase_t phase_q;
   ahb_req_t req;
   logic wr_en;
   logic rd_status;

   assign req = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite, hsize: hsize, hready: hready};

   // ----------------------------------------
   // Bus address phase
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         phase_q <= '0;
      end
      else if (req.hready)
      begin
         phase_q.valid <= req.hsel && (req.htrans == HTRANS_NONSEQ);
         phase_q.write <= req.hwrite;
         phase_q.addr <= req.haddr[7:0];
      end
   end

   assign wr_en = phase_q.valid && phase_q.write;
   assign rd_status = req.hsel && req.hready && (req.htrans == HTRANS_NONSEQ) && !req.hwrite
                      && (req.haddr[7:0] == OFS_STATUS);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata <= '0;
      end
      else if (req.hsel && req.hready && (req.htrans == HTRANS_NONSEQ) && !req.hwrite)
      begin
         unique case (req.haddr[7:0])
            OFS_MODE: hrdata <= 32'(mode_q);
            OFS_STATUS: hrdata <= 32'(status_q);
            OFS_MASK: hrdata <= 32'(mask_q);
            OFS_THRESH: hrdata <= 32'(thresh_q);
            OFS_INDIS: hrdata <= 32'(indis_q);
            OFS_SIO_OUT: hrdata <= 32'(sio_out_q);
            OFS_SIO_REF: hrdata <= 32'(sio_ref_q);
            OFS_PINS: hrdata <= 32'(level_q);
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------
   // Configuration writes
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mode_q <= RST_MODE;
         mask_q <= RST_MASK;
         thresh_q <= RST_THRESH;
         indis_q <= RST_INDIS;
         sio_out_q <= RST_SIO_OUT;
         sio_ref_q <= RST_SIO_REF;
      end
      else if (wr_en)
      begin
         unique case (phase_q.addr)
            OFS_MODE: mode_q <= hwdata[2*PINS-1:0];
            OFS_MASK: mask_q <= hwdata[PINS-1:0];
            OFS_THRESH: thresh_q <= hwdata[0];
            OFS_INDIS: indis_q <= hwdata[PINS-1:0];
            OFS_SIO_OUT: sio_out_q <= hwdata[PINS-1:0];
            OFS_SIO_REF: sio_ref_q <= hwdata[PINS-1:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Pin synchronisers and edge detect
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int i = 0; i < PINS; i++)
         begin
            sync_q[i] <= '0;
         end
         level_q <= '0;
      end
      else
      begin
         for (int i = 0; i < PINS; i++)
         begin
            sync_q[i] <= {sync_q[i][SYNC_STAGES-2:0], pin_in[i]};
            if (sync_q[i][1] == sync_q[i][2])
            begin
               level_q[i] <= sync_q[i][2];
            end
         end
      end
   end

   always_comb
   begin
      hit_d = '0;
      for (int i = 0; i < PINS; i++)
      begin
         if (sync_q[i][1] == sync_q[i][2] && sync_q[i][2] != level_q[i] && !indis_q[i])
         begin
            unique case (edge_mode_t'(mode_q[2*i +: MODE_W]))
               EDGE_NONE: hit_d[i] = 1'b0;
               EDGE_RISE: hit_d[i] = sync_q[i][2];
               EDGE_FALL: hit_d[i] = !sync_q[i][2];
               EDGE_BOTH: hit_d[i] = 1'b1;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Sticky status and interrupt
   // ----------------------------------------
   always_comb
   begin
      status_d = rd_status ? '0 : status_q;
      status_d = status_d | hit_d;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         status_q <= '0;
         pin_event <= '0;
      end
      else
      begin
         status_q <= status_d;
         pin_event <= hit_d;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |(status_d & ~mask_q);
      end
   end

   // ----------------------------------------
   // Pad control outputs
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         low_voltage_ttl_threshold <= 1'b0;
         input_buffer_disable <= '0;
         special_io_pin_regulated <= '0;
         pull_block <= '0;
      end
      else
      begin
         low_voltage_ttl_threshold <= thresh_q;
         input_buffer_disable <= indis_q;
         special_io_pin_regulated <= sio_out_q;
         for (int i = 0; i < PINS; i++)
         begin
            pull_block[i] <= sio_out_q[i] && pin_drive_mode[2*i+1];
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_status_set;
      @(posedge hclk) disable iff (!hresetn)
      |hit_d |=> ((status_q & $past(hit_d)) == $past(hit_d));
   endproperty
   a_status_set: assert property (p_status_set) else $error("event lost");

   property p_status_hold;
      @(posedge hclk) disable iff (!hresetn)
      (!rd_status && hit_d == '0) |=> (status_q == $past(status_q));
   endproperty
   a_status_hold: assert property (p_status_hold) else $error("status changed");

   property p_read_clears;
      @(posedge hclk) disable iff (!hresetn)
      (rd_status && hit_d == '0) |=> (status_q == '0);
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("read no clear");

   property p_irq;
      @(posedge hclk) disable iff (!hresetn)
      ##1 (irq == |($past(status_d) & ~$past(mask_q)));
   endproperty
   a_irq: assert property (p_irq) else $error("irq wrong");

   property p_none_mode;
      @(posedge hclk) disable iff (!hresetn)
      (mode_q[1:0] == EDGE_NONE) |-> !hit_d[0];
   endproperty
   a_none_mode: assert property (p_none_mode) else $error("none fired");

   property p_edge_only;
      @(posedge hclk) disable iff (!hresetn)
      hit_d[0] |=> !hit_d[0];
   endproperty
   a_edge_only: assert property (p_edge_only) else $error("level fired");

   property p_indis;
      @(posedge hclk) disable iff (!hresetn)
      indis_q[0] |-> !hit_d[0];
   endproperty
   a_indis: assert property (p_indis) else $error("disabled fired");

   property p_pull_block;
      @(posedge hclk) disable iff (!hresetn)
      (sio_out_q[0] && pin_drive_mode[1]) |=> pull_block[0];
   endproperty
   a_pull_block: assert property (p_pull_block) else $error("pull allowed");

   property p_thresh;
      @(posedge hclk) disable iff (!hresetn)
      $changed(thresh_q) |=> (low_voltage_ttl_threshold == $past(thresh_q));
   endproperty
   a_thresh: assert property (p_thresh) else $error("threshold lag");

   property p_read_data;
      @(posedge hclk) disable iff (!hresetn)
      rd_status |=> (hrdata == 32'($past(status_q)));
   endproperty
   a_read_data: assert property (p_read_data) else $error("status read lost");

   property p_rise_level;
      @(posedge hclk) disable iff (!hresetn)
      (mode_q[3:2] == EDGE_RISE && hit_d[1]) |-> sync_q[1][2];
   endproperty
   a_rise_level: assert property (p_rise_level) else $error("rise on fall");

   property p_fall_level;
      @(posedge hclk) disable iff (!hresetn)
      (mode_q[5:4] == EDGE_FALL && hit_d[2]) |-> !sync_q[2][2];
   endproperty
   a_fall_level: assert property (p_fall_level) else $error("fall on rise");

   property p_sio_level;
      @(posedge hclk) disable iff (!hresetn)
      $changed(sio_out_q) |=> (special_io_pin_regulated == $past(sio_out_q));
   endproperty
   a_sio_level: assert property (p_sio_level) else $error("output level lag");

   property p_ref_write;
      @(posedge hclk) disable iff (!hresetn)
      (wr_en && phase_q.addr == OFS_SIO_REF) |=> (sio_ref_q == $past(hwdata[PINS-1:0]));
   endproperty
   a_ref_write: assert property (p_ref_write) else $error("reference not taken");

endmodule

// file: tb/pin_side_model.sv
/*
 Far side of the port: external pin drivers and the interrupt controller input.
 Assumes the bench sets the wanted pin levels and that irq is seen as a level.
*/
`timescale 1ns/1ps
module pin_side_model
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [7:0] level,
   input wire logic irq,
   output logic [7:0] pin_in,
   output logic [7:0] irq_rises
);
   logic irq_q;

   // ----------------------------------------
   // Pins, off the clock edge
   // ----------------------------------------
   always @(posedge hclk)
      pin_in <= #7 level;

   // ----------------------------------------
   // Controller side: counts requests
   // ----------------------------------------
   always @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         irq_q <= 1'b0;
         irq_rises <= 8'h00;
      end
      else
      begin
         irq_q <= irq;
         if (irq && !irq_q)
            irq_rises <= irq_rises + 8'h01;
      end
endmodule

// file: tb/test_port_event_unit.sv
/*
 Self-checking bench for the port event unit, one task per scenario.
 Assumes one AHB-Lite slave whose hreadyout is fed back as hready.
*/
`timescale 1ns/1ps
module test_port_event_unit import port_event_pkg::*;;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, lvt;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] level, pin_in, ibd, sreg, pblk, irq_rises, pev;
   logic [15:0] pin_drive_mode;
   int errors, n_tests;

   port_event_unit port_event_unit_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
      .pin_drive_mode(pin_drive_mode), .irq(irq), .low_voltage_ttl_threshold(lvt),
      .input_buffer_disable(ibd), .special_io_pin_regulated(sreg), .pull_block(pblk), .pin_event(pev));
   pin_side_model pin_side_model_inst (.hclk(hclk), .hresetn(hresetn), .level(level), .irq(irq),
      .pin_in(pin_in), .irq_rises(irq_rises));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic complete_run();
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_ready();
      int k;
      k = 0;
      do
      begin
         @(posedge hclk);
         k++;
      end
      while (hreadyout !== 1'b1 && k < 50);
      if (hreadyout !== 1'b1)
      begin
         errors++;
         $display("[ERR] %0t bus wait ran out", $time);
         complete_run();
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= 3'h2;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask

   task automatic wait_event(input logic [7:0] exp);
      int k;
      k = 0;
      do
      begin
         @(posedge hclk);
         k++;
      end
      while (pev === 8'h00 && k < 20);
      if (pev === 8'h00)
      begin
         errors++;
         $display("[ERR] %0t event wait ran out", $time);
         complete_run();
      end
      else
      begin
         chk(32'(pev), 32'(exp));
         @(posedge hclk);
         chk(32'(pev), 32'h0);
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      chk(32'(irq), 32'h0);
      chk(32'(hreadyout), 32'h1);
      chk(32'(hresp), 32'h0);
      rdchk(OFS_MODE, {16'h0, RST_MODE});
      rdchk(OFS_MASK, {24'h0, RST_MASK});
      rdchk(OFS_THRESH, {31'h0, RST_THRESH});
      rdchk(OFS_INDIS, {24'h0, RST_INDIS});
      rdchk(OFS_SIO_OUT, {24'h0, RST_SIO_OUT});
      rdchk(OFS_SIO_REF, {24'h0, RST_SIO_REF});
      rdchk(8'h20, 32'h0);
   endtask

   task automatic t_edges();
      wr(OFS_MODE, 32'he4e4);
      level <= 8'hff;
      wait_event(8'haa);
      chk(32'(irq), 32'h1);
      rdchk(OFS_STATUS, 32'haa);
      rdchk(OFS_STATUS, 32'h0);
      cyc(2);
      chk(32'(irq), 32'h0);
      level <= 8'h00;
      wait_event(8'hcc);
      rdchk(OFS_STATUS, 32'hcc);
      chk(32'(irq_rises), 32'h2);
   endtask

   task automatic t_mask();
      wr(OFS_MASK, 32'hff);
      level <= 8'hff;
      cyc(8);
      chk(32'(irq), 32'h0);
      wr(OFS_MASK, 32'h0);
      cyc(2);
      chk(32'(irq), 32'h1);
      rdchk(OFS_STATUS, 32'haa);
      level <= 8'h00;
      cyc(8);
      rdchk(OFS_STATUS, 32'hcc);
   endtask

   task automatic t_midreset();
      wr(OFS_MODE, 32'h5555);
      level <= 8'hff;
      wait_event(8'hff);
      chk(32'(irq), 32'h1);
      hresetn <= 1'b0;
      @(posedge hclk);
      chk(32'(irq), 32'h0);
      chk(32'(pev), 32'h0);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdchk(OFS_STATUS, 32'h0);
      rdchk(OFS_MODE, {16'h0, RST_MODE});
      level <= 8'h00;
      cyc(8);
      rdchk(OFS_STATUS, 32'h0);
   endtask

   task automatic t_indis();
      wr(OFS_INDIS, 32'h0f);
      wr(OFS_MODE, 32'hffff);
      cyc(2);
      chk(32'(ibd), 32'h0f);
      level <= 8'hff;
      cyc(8);
      rdchk(OFS_PINS, 32'hff);
      rdchk(OFS_STATUS, 32'hf0);
      wr(OFS_STATUS, 32'hff);
      rdchk(OFS_STATUS, 32'h0);
      wr(OFS_INDIS, 32'h0);
      level <= 8'h00;
      cyc(8);
      rdchk(OFS_STATUS, 32'hff);
   endtask

   task automatic t_cfg();
      wr(OFS_THRESH, 32'h1);
      wr(OFS_SIO_OUT, 32'h07);
      pin_drive_mode <= 16'h00b9;
      wr(OFS_SIO_REF, 32'he4);
      cyc(2);
      chk(32'(lvt), 32'h1);
      chk(32'(sreg), 32'h07);
      chk(32'(pblk), 32'h06);
      rdchk(OFS_SIO_REF, 32'he4);
      rdchk(OFS_THRESH, 32'h1);
   endtask

   // ----------------------------------------
   // Clock, watchdog, main sequence
   // ----------------------------------------
   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   initial
   begin
      repeat (20000) @(posedge hclk);
      errors++;
      $display("[ERR] %0t run limit reached", $time);
      complete_run();
   end

   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h0;
      hwdata = 32'h0;
      level = 8'h00;
      pin_drive_mode = 16'h0000;
      errors = 0;
      n_tests = 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_edges();
      t_mask();
      t_midreset();
      t_indis();
      t_cfg();
      complete_run();
   end
endmodule
